// ---- bench/plfc_asserts.sv ----
// Port checker of the position loop, bound into plfc_top.
// Assumes the register map and the pin sync of the design, four cycles on a rise and three on a fall.
`timescale 1ns/1ns
`default_nettype none
// ==========
// Checker module.
module plfc_chk (
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic [5:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic        forward_run_input_i,
    input wire logic        reverse_run_input_i,
    input wire logic        servo_on_input_i,
    input wire logic [39:0] speed_cmd_o,
    input wire logic        in_position_output_o,
    input wire logic        position_overrun_fault_o
);
    logic src;
    wire  clr = wr_i && addr_i == 6'h0C && wdata_i[1];
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    // Source shadow: direction gating is contact mode only.
    always_ff @(posedge clock_i or posedge rst_i)
        if (rst_i)
            src <= 1'b0;
        else if (wr_i && addr_i == 6'h00)
            src <= wdata_i[0];
    // Eight steady cycles cover pin sync and output register.
    rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data without a read");
    hole_read_a: assert property (rd_i && addr_i == 6'h3F |=> rdata_o == 32'h0)
        else $error("unused offset read non-zero");
    status_fault_a: assert property (rd_i && addr_i == 6'h0C
        |=> rdata_o[1] == $past(position_overrun_fault_o)) else $error("fault bit wrong");
    fault_hold_a: assert property (position_overrun_fault_o && !clr
        |=> position_overrun_fault_o) else $error("fault dropped by itself");
    fault_speed_a: assert property (position_overrun_fault_o [*2]
        |-> speed_cmd_o == 40'h0) else $error("speed while faulted");
    servo_speed_a: assert property (!servo_on_input_i [*8]
        |-> speed_cmd_o == 40'h0) else $error("speed without servo on");
    fwd_block_a: assert property ((!src && !forward_run_input_i) [*8]
        |-> $signed(speed_cmd_o) <= 0) else $error("forward speed while open");
    rev_block_a: assert property ((!src && !reverse_run_input_i) [*8]
        |-> $signed(speed_cmd_o) >= 0) else $error("reverse speed while open");
    // Main scenarios reached.
    cover property ($rose(position_overrun_fault_o));
    cover property ($fell(in_position_output_o));
    cover property (rd_i && addr_i == 6'h0D);
endmodule : plfc_chk
bind plfc_top plfc_chk i_chk (.clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .forward_run_input_i, .reverse_run_input_i, .servo_on_input_i, .speed_cmd_o,
    .in_position_output_o, .position_overrun_fault_o);
`default_nettype wire

// ---- bench/plfc_motor.sv ----
// Encoder model: turns the speed command into feedback pulses.
// Assumes synced drive pins; pulses last 8 cycles, or 32 with slow_i.
`timescale 1ns/1ns
`default_nettype none
// ==========
// Encoder; slow_i stretches each pulse, the gap between pulses stays 9 cycles.
module plfc_motor (
    input  wire logic        clock_i,
    input  wire logic        slow_i,
    input  wire logic [39:0] speed_i,
    output var  logic        fb_pulse_o,
    output var  logic        fb_dir_o
);
    int cnt = 0;
    initial fb_pulse_o = 1'b0;
    initial fb_dir_o = 1'b1;
    // Speed is sampled between pulses so the droop settles, never overshooting.
    always @(posedge clock_i) begin
        fb_pulse_o <= cnt > 8;
        if (cnt > 0)
            cnt <= cnt - 1;
        else if (speed_i != 40'h0) begin
            fb_dir_o <= ~speed_i[39];
            cnt      <= slow_i ? 40 : 16;
        end
    end
endmodule : plfc_motor
`default_nettype wire

// ---- bench/plfc_top_tb.sv ----
// Self-checking bench of the position loop.
// Assumes design, encoder model and checker compile first.
`timescale 1ns/1ns
`default_nettype none
// ==========
// Bench top.
module plfc_top_tb;
    logic        clock_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic        fwd = 1'b0, servo = 1'b0, tp = 1'b0, slow = 1'b0, rev = 1'b0, tdir = 1'b1;
    logic [3:0]  sel = 4'h0;
    logic [5:0]  addr_i = 6'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o, mon, v, d, tot = 32'h0;
    logic [39:0] speed;
    logic        inpos, fault, fbp, fbd;
    int          failures = 0, checks = 0;
    // 100 ns clock; long counts shortened.
    always #50 clock_i = ~clock_i;
    plfc_top #(.STOP_TICK_CYC(10), .FF_TICK_CYC(4), .RATE_WIN_CYC(8), .FEED_PER_CYC(20))
    i_dut (.clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .forward_run_input_i(fwd), .reverse_run_input_i(rev), .speed_select_high_i(sel[2]),
        .speed_select_mid_i(sel[1]), .speed_select_low_i(sel[0]), .speed_select_ext_i(sel[3]),
        .servo_on_input_i(servo), .fb_pulse_i(fbp), .fb_dir_i(fbd), .train_pulse_i(tp),
        .train_dir_i(tdir), .speed_cmd_o(speed), .in_position_output_o(inpos),
        .position_overrun_fault_o(fault), .monitor_o(mon));
    plfc_motor i_mot (.clock_i, .slow_i(slow), .speed_i(speed), .fb_pulse_o(fbp), .fb_dir_o(fbd));
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask : cyc
    task automatic wr(input logic [5:0] a, input logic [31:0] x);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= x;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i    <= 1'b0;
    endtask : wr
    // Read data stand one cycle only, so take them mid-cycle.
    task automatic rd(input logic [5:0] a, output logic [31:0] x);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i   <= 1'b0;
        @(negedge clock_i);
        x = rdata_o;
        @(posedge clock_i);
    endtask : rd
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        failures += int'(got !== exp);
    endtask : cmp
    task automatic finish_test;
        $display("checks %0d, failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    // Bounded wait for idle with zero droop.
    task automatic settle;
        for (int k = 0; k < 300; k++) begin
            rd(6'h0C, v);
            rd(6'h0D, d);
            if (k > 8 && v[2] === 1'b0 && d === 32'h0)
                break;
        end
    endtask : settle
    task automatic t_reset;
        logic [5:0]  a [13] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06,
                                6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h3F};
        logic [31:0] e [13] = '{32'h0, 32'h0, 32'h1, 32'h19, 32'h0, 32'h0, 32'h64,
                                32'h28, 32'h270F, 32'h0, 32'h17, 32'h24, 32'h0};
        wr(6'h3F, 32'h5);
        foreach (a[i]) begin
            rd(a[i], v);
            cmp(v, e[i]);
        end
        $display("reset values done");
    endtask : t_reset
    // Contact feed: selection first, then direction.
    task automatic t_feed(input logic [3:0] s, input logic [5:0] a, input logic [31:0] n,
                          input logic on);
        wr(a, n);
        servo <= on;
        sel   <= s;
        cyc(6);
        fwd   <= 1'b1;
        settle;
        fwd   <= 1'b0;
        sel   <= 4'h0;
        tot   = on ? tot + n : tot;
        cmp(mon, {16'h0, tot[15:0]});
        rd(6'h0D, v);
        cmp(v, 32'h0);
        cmp({31'h0, inpos}, 32'h1);
        $display("feed %h done", s);
    endtask : t_feed
    task automatic t_train;
        wr(6'h00, 32'h1);
        servo <= 1'b1;
        repeat (3) begin
            tp <= 1'b1;
            cyc(5);
            tp <= 1'b0;
            cyc(5);
        end
        settle;
        cmp(mon, {16'h0, tot[15:0] + 16'h3});
        wr(6'h00, 32'h0);
        $display("train done");
    endtask : t_train
    // Level zero trips once droop leaves zero; 9999 disables the check.
    task automatic t_fault;
        wr(6'h06, 32'h0);
        cyc(3);
        cmp({31'h0, inpos}, 32'h0);
        wr(6'h07, 32'h0);
        sel <= 4'h4;
        cyc(6);
        fwd <= 1'b1;
        for (int k = 0; k < 200 && fault !== 1'b1; k++)
            cyc(1);
        cyc(2);
        cmp({31'h0, fault}, 32'h1);
        cmp(speed[31:0], 32'h0);
        fwd <= 1'b0;
        wr(6'h07, 32'h270F);
        wr(6'h0C, 32'h2);
        rd(6'h0C, v);
        cmp({30'h0, v[1:0]}, 32'h0);
        $display("fault done");
    endtask : t_fault
    initial begin
        cyc(4);
        rst_i <= 1'b0;
        t_reset;
        wr(6'h01, 32'h1);
        wr(6'h08, 32'h0);
        t_feed(4'h4, 6'h20, 32'h5, 1'b1);
        slow <= 1'b1;
        t_feed(4'h9, 6'h30, 32'h3, 1'b1);
        t_feed(4'h3, 6'h26, 32'h2, 1'b0);
        t_train;
        t_fault;
        finish_test;
    end
    // Watchdog of 50000 cycles, far above the run.
    initial begin
        #5000000 failures++;
        finish_test;
    end
endmodule : plfc_top_tb
`default_nettype wire

// ---- rtl/plfc_params.svh ----
// Constants of the position loop block.
// Assumes one 10 MHz clock.
// ==========================================================================
// Operation
// - Source setting 0 takes contact feeds, 1 takes the external pulse train.
// - Speed command drives command count minus feedback count to zero.
// - Each command pulse adds to the deviation counter; droop gives speed.
// - Each feedback pulse counts the deviation counter down while running.
// - With commands ceased, speed falls with droop and stops at zero.
// - In-position output is on while droop magnitude is below the width.
// - Droop above the excessive level flags a position error.
// - Command pulses are scaled by gear numerator over denominator.
// - Position gain 0 to 150 per second multiplies droop, default 25.
// - Feed-forward of 0 to 100 percent offsets droop lag, default 0.
// - Feed-forward passes a first-order lag of 0 to 5 seconds.
// - Monitor selector 0 to 5 or 9999 picks the displayed count.
// - Sudden-stop deceleration time 0 to 360.0 s, default zero.
// - In contact mode run inputs permit only their direction.
// - Open forward input inhibits forward; open reverse inhibits reverse; the code inhibits only with source setting 0.
// - Fifteen feeds, each lower and upper part 0 to 9999, default zero.
// - Feed equals upper times ten thousand plus lower, in feedback pulses; the code counts command pulses ahead of the gear.
// - Without extension, high, mid, low pick feeds one to seven.
// - Contact feeds are relative moves only; no homing sequence.
// - Contact feeding is accepted only while servo-on is active.
// - Servo-on uses input function 23; in-position uses output function 36.
// - Excessive error shows the overrun fault and stops; 9999 disables it.
`ifndef PLFC_PARAMS_SVH
`define PLFC_PARAMS_SVH
// ==========================================================================
// Register offsets.
`define PLFC_A_SRC      6'h00
`define PLFC_A_GNUM     6'h01
`define PLFC_A_GDEN     6'h02
`define PLFC_A_GAIN     6'h03
`define PLFC_A_FFG      6'h04
`define PLFC_A_FFT      6'h05
`define PLFC_A_INPOS    6'h06
`define PLFC_A_EXCESS   6'h07
`define PLFC_A_MON      6'h08
`define PLFC_A_STOPDEC  6'h09
`define PLFC_A_INFUNC   6'h0A
`define PLFC_A_OUTFUNC  6'h0B
`define PLFC_A_STATUS   6'h0C
`define PLFC_A_DROOP    6'h0D
`define PLFC_A_MONVAL   6'h0E
`define PLFC_A_FEED     6'h20
`define PLFC_FEED_N     4'hF
// ==========================================================================
// Reset values and special settings.
`define PLFC_RV_GDEN    15'h0001
`define PLFC_RV_GAIN    8'h19
`define PLFC_RV_INPOS   15'h0064
`define PLFC_RV_EXCESS  14'h0028
`define PLFC_OFF_9999   14'h270F
`define PLFC_FN_SERVO   8'h17
`define PLFC_FN_INPOS   8'h24
`define PLFC_UPPER_WT   27'h0002710
`define PLFC_EXC_UNIT   32'h000003E8
`define PLFC_PCT_FULL   32'sh00000064
`define PLFC_ST_CLR     1
// ==========================================================================
// Timing.
`define PLFC_STOP_TICK_CYC   1000000
`define PLFC_FF_TICK_CYC     100000
`define PLFC_RATE_WIN_CYC    10000
`define PLFC_FEED_PER_CYC    100
`endif

// ---- rtl/plfc_pkg.sv ----
// Types shared by the position loop block.
// Assumes the constants header is included alongside.
// ==========================================================================
// Feed sequencer states.
package plfc_pkg;
    typedef enum logic [1:0] {
        fs_idle = 2'b00,
        fs_run  = 2'b01,
        fs_stop = 2'b10
    } plfc_feed_st_t;
    typedef logic signed [31:0] plfc_count_t;
endpackage : plfc_pkg

// ---- rtl/plfc_top.sv ----
// Position loop with gear, gain, feed-forward and contact feeds.
// Assumes asynchronous pins on the encoder, pulse train and contact inputs.
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "plfc_params.svh"

// ==========================================================================
// Three-stage pin sync; output goes high when stages two and three are both high, low when they differ, else holds.
module plfc_sync #(
    parameter int W = 1
) (
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output var  logic [W-1:0] q_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // Stage one feeds only stage two, so no glitch reaches the logic.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s1  <= '0;
            s2  <= '0;
            s3  <= '0;
            q_o <= '0;
        end else begin
            s1  <= d_i;
            s2  <= s1;
            s3  <= s2;
            q_o <= (s2 & s3) | (q_o & ~(s2 ^ s3));
        end
    end
endmodule : plfc_sync

// ==========================================================================
// Top level of the position loop.
module plfc_top #(
    parameter int STOP_TICK_CYC = `PLFC_STOP_TICK_CYC,
    parameter int FF_TICK_CYC   = `PLFC_FF_TICK_CYC,
    parameter int RATE_WIN_CYC  = `PLFC_RATE_WIN_CYC,
    parameter int FEED_PER_CYC  = `PLFC_FEED_PER_CYC
) (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic [5:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output var  logic [31:0] rdata_o,
    input  wire logic        forward_run_input_i,
    input  wire logic        reverse_run_input_i,
    input  wire logic        speed_select_high_i,
    input  wire logic        speed_select_mid_i,
    input  wire logic        speed_select_low_i,
    input  wire logic        speed_select_ext_i,
    input  wire logic        servo_on_input_i,
    input  wire logic        fb_pulse_i,
    input  wire logic        fb_dir_i,
    input  wire logic        train_pulse_i,
    input  wire logic        train_dir_i,
    output var  logic [39:0] speed_cmd_o,
    output var  logic        in_position_output_o,
    output var  logic        position_overrun_fault_o,
    output var  logic [31:0] monitor_o
);
    // Settings.
    logic        src;
    logic [14:0] gnum;
    logic [14:0] gden;
    logic [7:0]  gain;
    logic [6:0]  ffg;
    logic [8:0]  fft;
    logic [14:0] inpos_w;
    logic [13:0] excess;
    logic [13:0] mon_sel;
    logic [11:0] stop_dec;
    logic [7:0]  in_func;
    logic [7:0]  out_func;
    logic [13:0] feed_lo [0:14];
    logic [13:0] feed_hi [0:14];
    // Loop state.
    plfc_pkg::plfc_count_t   droop;
    plfc_pkg::plfc_count_t   cmd_cum;
    plfc_pkg::plfc_count_t   fb_cum;
    plfc_pkg::plfc_count_t   rate_cnt;
    plfc_pkg::plfc_count_t   rate_q;
    plfc_pkg::plfc_count_t   ff_y;
    plfc_pkg::plfc_feed_st_t fstate;
    logic [26:0] remain;
    logic        fdir;
    logic        fault;
    logic [23:0] gacc;
    logic        gdir;
    logic [23:0] feed_cnt;
    logic [23:0] win_cnt;
    logic [23:0] fft_cnt;
    logic [23:0] stp_cnt;
    logic [11:0] dec_cnt;
    logic        fwd_q;
    logic        rev_q;
    logic        fbp_q;
    logic        trp_q;

    // Pin synchronisation.
    logic [8:0] pin;
    plfc_sync #(.W(9)) u_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .d_i     ({forward_run_input_i, reverse_run_input_i, speed_select_high_i,
                   speed_select_mid_i, speed_select_low_i, speed_select_ext_i,
                   servo_on_input_i, fb_pulse_i, train_pulse_i}),
        .q_o     (pin)
    );
    logic [1:0] dirs;
    plfc_sync #(.W(2)) u_sync_dir (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .d_i     ({fb_dir_i, train_dir_i}),
        .q_o     (dirs)
    );

    // Input decode and edges.
    wire fwd     = pin[8];
    wire rev     = pin[7];
    wire servo   = pin[2] && (in_func == `PLFC_FN_SERVO);
    wire fb_edge = pin[1] && !fbp_q;
    wire tr_edge = pin[0] && !trp_q;
    wire fwd_up  = fwd && !fwd_q;
    wire rev_up  = rev && !rev_q;

    // Feed selection from the speed select contacts.
    function automatic logic [3:0] sel_decode(input logic [3:0] s);
        logic [3:0] r;
        r = 4'h0;
        if (s[0]) begin
            r = {1'b1, s[3:1]};
        end else begin
            case (s[3:1])
                3'h4:    r = 4'h1;
                3'h2:    r = 4'h2;
                3'h1:    r = 4'h3;
                3'h3:    r = 4'h4;
                3'h5:    r = 4'h5;
                3'h6:    r = 4'h6;
                3'h7:    r = 4'h7;
                default: r = 4'h0;
            endcase
        end
        return r;
    endfunction : sel_decode

    wire [3:0]  sel_idx  = sel_decode({pin[6], pin[5], pin[4], pin[3]});
    wire [3:0]  sel_ent  = sel_idx - 4'h1;
    // Amount in command pulses ahead of the gear, upper part weighted ten thousand.
    wire [26:0] feed_amt = 27'(feed_hi[sel_ent]) * `PLFC_UPPER_WT
                         + 27'(feed_lo[sel_ent]);
    // Start only on a direction edge, so a later selection changes nothing.
    wire start = (fstate == plfc_pkg::fs_idle) && !src && servo && !fault
               && (sel_idx != 4'h0) && (fwd_up ^ rev_up);
    wire feed_tick = (feed_cnt == 24'(FEED_PER_CYC - 1));
    wire feed_pls  = (fstate == plfc_pkg::fs_run) && feed_tick && (remain != 27'h0);
    wire dir_ok    = fdir ? fwd : rev;
    wire abort     = (fstate == plfc_pkg::fs_run)
                   && (!dir_ok || !servo || fault);
    wire stp_tick  = (stp_cnt == 24'(STOP_TICK_CYC - 1));
    wire stop_done = (fstate == plfc_pkg::fs_stop) && (dec_cnt >= stop_dec);

    // Command source and electronic gear.
    wire        cmd_raw = src ? (servo && tr_edge) : feed_pls;
    wire        cmd_dir = src ? dirs[0] : fdir;
    wire [23:0] gsum    = gacc + (cmd_raw ? 24'(gnum) : 24'h0);
    wire        gout    = (gden != 15'h0) && (gsum >= 24'(gden));
    wire        odir    = cmd_raw ? cmd_dir : gdir;
    wire        fb_cnt  = fb_edge && servo;

    // Droop magnitude and its checks.
    wire [31:0] dabs     = droop[31] ? 32'(-droop) : 32'(droop);
    wire        inpos    = dabs < 32'(inpos_w);
    wire        exc_set  = (excess != `PLFC_OFF_9999)
                         && (dabs > 32'(excess) * `PLFC_EXC_UNIT);
    wire        clr_f    = wr_i && (addr_i == `PLFC_A_STATUS) && wdata_i[`PLFC_ST_CLR];
    wire        next_fault = exc_set || (fault && !clr_f);

    // Speed command from gain and filtered feed-forward.
    plfc_pkg::plfc_count_t ffg_s;
    plfc_pkg::plfc_count_t ff_x;
    plfc_pkg::plfc_count_t ff_div;
    assign ffg_s  = $signed({25'h0, ffg});
    assign ff_x   = (rate_q * ffg_s) / `PLFC_PCT_FULL;
    assign ff_div = $signed({23'h0, fft} + 32'h1);
    wire        ff_tick = (fft_cnt == 24'(FF_TICK_CYC - 1));
    wire        win_end = (win_cnt == 24'(RATE_WIN_CYC - 1));
    wire signed [39:0] pterm  = 40'(droop) * $signed({32'h0, gain});
    wire signed [39:0] spd    = pterm + 40'(ff_y);
    wire        blk_dir = !src && ((spd > 40'sh0 && !fwd)
                                || (spd < 40'sh0 && !rev));
    wire        zero_spd = fault || !servo || blk_dir || stop_done;

    // Register read path; unmapped offsets read zero.
    wire        is_feed = (addr_i[5:1] >= 5'h10) && (addr_i[4:1] < `PLFC_FEED_N);
    wire [3:0]  wr_ent  = addr_i[4:1];
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0;
        case (addr_i)
            `PLFC_A_SRC:     rmux = {31'h0, src};
            `PLFC_A_GNUM:    rmux = {17'h0, gnum};
            `PLFC_A_GDEN:    rmux = {17'h0, gden};
            `PLFC_A_GAIN:    rmux = {24'h0, gain};
            `PLFC_A_FFG:     rmux = {25'h0, ffg};
            `PLFC_A_FFT:     rmux = {23'h0, fft};
            `PLFC_A_INPOS:   rmux = {17'h0, inpos_w};
            `PLFC_A_EXCESS:  rmux = {18'h0, excess};
            `PLFC_A_MON:     rmux = {18'h0, mon_sel};
            `PLFC_A_STOPDEC: rmux = {20'h0, stop_dec};
            `PLFC_A_INFUNC:  rmux = {24'h0, in_func};
            `PLFC_A_OUTFUNC: rmux = {24'h0, out_func};
            `PLFC_A_STATUS:  rmux = {28'h0, servo, fstate != plfc_pkg::fs_idle,
                                     fault, inpos};
            `PLFC_A_DROOP:   rmux = droop;
            `PLFC_A_MONVAL:  rmux = monitor_o;
            default: begin
                if (is_feed) begin
                    rmux = {18'h0, addr_i[0] ? feed_hi[wr_ent] : feed_lo[wr_ent]};
                end
            end
        endcase
    end

    // Monitor selection; out-of-range selections show zero.
    logic [31:0] next_mon;
    always_comb begin
        case (mon_sel)
            14'h0000: next_mon = {16'h0, cmd_cum[15:0]};
            14'h0001: next_mon = {16'h0, cmd_cum[31:16]};
            14'h0002: next_mon = {16'h0, fb_cum[15:0]};
            14'h0003: next_mon = {16'h0, fb_cum[31:16]};
            14'h0004: next_mon = {16'h0, droop[15:0]};
            14'h0005: next_mon = {16'h0, droop[31:16]};
            `PLFC_OFF_9999: next_mon = speed_cmd_o[31:0];
            default:  next_mon = 32'h0;
        endcase
    end

    // Settings; reads answer in the next cycle.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            src      <= 1'b0;
            gnum     <= 15'h0000;
            gden     <= `PLFC_RV_GDEN;
            gain     <= `PLFC_RV_GAIN;
            ffg      <= 7'h00;
            fft      <= 9'h000;
            inpos_w  <= `PLFC_RV_INPOS;
            excess   <= `PLFC_RV_EXCESS;
            mon_sel  <= `PLFC_OFF_9999;
            stop_dec <= 12'h000;
            in_func  <= `PLFC_FN_SERVO;
            out_func <= `PLFC_FN_INPOS;
            rdata_o  <= 32'h0;
        end else begin
            rdata_o <= rd_i ? rmux : 32'h0;
            if (wr_i) begin
                case (addr_i)
                    `PLFC_A_SRC:     src      <= wdata_i[0];
                    `PLFC_A_GNUM:    gnum     <= wdata_i[14:0];
                    `PLFC_A_GDEN:    gden     <= wdata_i[14:0];
                    `PLFC_A_GAIN:    gain     <= wdata_i[7:0];
                    `PLFC_A_FFG:     ffg      <= wdata_i[6:0];
                    `PLFC_A_FFT:     fft      <= wdata_i[8:0];
                    `PLFC_A_INPOS:   inpos_w  <= wdata_i[14:0];
                    `PLFC_A_EXCESS:  excess   <= wdata_i[13:0];
                    `PLFC_A_MON:     mon_sel  <= wdata_i[13:0];
                    `PLFC_A_STOPDEC: stop_dec <= wdata_i[11:0];
                    `PLFC_A_INFUNC:  in_func  <= wdata_i[7:0];
                    `PLFC_A_OUTFUNC: out_func <= wdata_i[7:0];
                    default:         src      <= src;
                endcase
            end
        end
    end

    // Feed table, fifteen lower and upper parts.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < 15; i++) begin
                feed_lo[i] <= 14'h0000;
                feed_hi[i] <= 14'h0000;
            end
        end else if (wr_i && is_feed) begin
            if (addr_i[0]) begin
                feed_hi[wr_ent] <= wdata_i[13:0];
            end else begin
                feed_lo[wr_ent] <= wdata_i[13:0];
            end
        end
    end

    // Feed sequencer: relative moves only, there is no homing state.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            fstate <= plfc_pkg::fs_idle;
            remain <= 27'h0;
            fdir   <= 1'b0;
        end else begin
            case (fstate)
                plfc_pkg::fs_idle: begin
                    if (start) begin
                        fstate <= plfc_pkg::fs_run;
                        remain <= feed_amt;
                        fdir   <= fwd_up;
                    end
                end
                plfc_pkg::fs_run: begin
                    if (abort) begin
                        fstate <= plfc_pkg::fs_stop;
                    end else if (remain == 27'h0) begin
                        fstate <= plfc_pkg::fs_idle;
                    end else if (feed_pls) begin
                        remain <= remain - 27'h1;
                    end
                end
                plfc_pkg::fs_stop: begin
                    if (stop_done) begin
                        fstate <= plfc_pkg::fs_idle;
                        remain <= 27'h0;
                    end
                end
                default: fstate <= plfc_pkg::fs_idle;
            endcase
        end
    end

    // Tick dividers.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            feed_cnt <= 24'h0;
            win_cnt  <= 24'h0;
            fft_cnt  <= 24'h0;
            stp_cnt  <= 24'h0;
            dec_cnt  <= 12'h000;
        end else begin
            feed_cnt <= feed_tick ? 24'h0 : feed_cnt + 24'h1;
            win_cnt  <= win_end ? 24'h0 : win_cnt + 24'h1;
            fft_cnt  <= ff_tick ? 24'h0 : fft_cnt + 24'h1;
            stp_cnt  <= stp_tick ? 24'h0 : stp_cnt + 24'h1;
            if (fstate != plfc_pkg::fs_stop) begin
                dec_cnt <= 12'h000;
            end else if (stp_tick && !stop_done) begin
                dec_cnt <= dec_cnt + 12'h001;
            end
        end
    end

    // Gear accumulator; one scaled pulse leaves per cycle at most.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            gacc <= 24'h0;
            gdir <= 1'b0;
        end else begin
            gdir <= odir;
            gacc <= gout ? gsum - 24'(gden) : gsum;
        end
    end

    // Deviation counter and cumulative counts; a sudden stop drops droop.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            droop   <= 32'sh0;
            cmd_cum <= 32'sh0;
            fb_cum  <= 32'sh0;
        end else begin
            if (stop_done) begin
                droop <= 32'sh0;
            end else begin
                droop <= droop + (gout ? (odir ? 32'sh1 : -32'sh1) : 32'sh0)
                       - (fb_cnt ? (dirs[1] ? 32'sh1 : -32'sh1) : 32'sh0);
            end
            if (gout) begin
                cmd_cum <= cmd_cum + (odir ? 32'sh1 : -32'sh1);
            end
            if (fb_cnt) begin
                fb_cum <= fb_cum + (dirs[1] ? 32'sh1 : -32'sh1);
            end
        end
    end

    // Command rate window and lag filter for feed-forward.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rate_cnt <= 32'sh0;
            rate_q   <= 32'sh0;
            ff_y     <= 32'sh0;
        end else begin
            if (win_end) begin
                rate_q   <= rate_cnt;
                rate_cnt <= 32'sh0;
            end else if (gout) begin
                rate_cnt <= rate_cnt + (odir ? 32'sh1 : -32'sh1);
            end
            if (ff_tick) begin
                ff_y <= ff_y + (ff_x - ff_y) / ff_div;
            end
        end
    end

    // Outputs, edge history and fault flag; a new error beats a clear.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            speed_cmd_o              <= 40'h0;
            in_position_output_o     <= 1'b0;
            position_overrun_fault_o <= 1'b0;
            monitor_o                <= 32'h0;
            fault                    <= 1'b0;
            fwd_q                    <= 1'b0;
            rev_q                    <= 1'b0;
            fbp_q                    <= 1'b0;
            trp_q                    <= 1'b0;
        end else begin
            speed_cmd_o              <= zero_spd ? 40'h0 : spd;
            in_position_output_o     <= inpos && (out_func == `PLFC_FN_INPOS);
            position_overrun_fault_o <= next_fault;
            monitor_o                <= next_mon;
            fault                    <= next_fault;
            fwd_q                    <= fwd;
            rev_q                    <= rev;
            fbp_q                    <= pin[1];
            trp_q                    <= pin[0];
        end
    end
endmodule : plfc_top
`default_nettype wire
